// ---- src/pll_clock_source_control.sv ----
// The Wishbone register port is this design's own decision.
`timescale 1ns/100ps
// Functional notes
// - Drive pump current select from config bits [7:6] to the analog pump.
// - Config bits [3:2] pick lock window (20/400 ns) and count (8/16).
// - Config bits [1:0] choose crystal, PLL or real-time-clock oscillator.
// - Writing 11 to the source field keeps the previous source.
// - Pump and sensitivity fields are writable only while PLL is disabled.
// - Switching to PLL is refused while PLL is disabled or unlocked.
// - Clearing the PLL enable is ignored while PLL is the source.
// - Lock is synchronized and readable as status bit 5.
// - Rising lock sets bit 4 flag, held until the register is read or a one is written to bit 4.
// - Falling lock sets bit 3 flag, held until the register is read or a one is written to bit 3.
// - Lock interrupt only when bit 2 enable is set.
// - Unlock interrupt only when bit 1 enable is set.
// - Bit 0 enables the PLL; both registers reset to zero.
// - Lock and unlock events feed the interrupt output.
// - Lock declared after enough consecutive reference cycles within the window.
// - After reset PLL is off and the crystal clocks the system.
// - PLL source is allowed only once lock is reached, for clean switching.
module pll_clock_source_control (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [pll_clock_pkg::ADR_W-1:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic ref_clk_i,
    input wire logic phase_ok_i,
    output logic [1:0] pump_current_select_o,
    output logic lock_window_long_o,
    output logic pll_enable_o,
    output logic [1:0] system_clock_source_select_o,
    output logic irq_o
);

    // =========================================================
    // State
    typedef struct packed {
        logic [1:0] pump;
        logic [1:0] sens;
        logic [1:0] src;
        logic en;
        logic lock_ie;
        logic unlock_ie;
        logic lock_flag;
        logic unlock_flag;
        logic ref_s1;
        logic ref_s2;
        logic ref_s3;
        logic ok_s1;
        logic ok_s2;
        logic [4:0] cnt;
        logic locked;
        logic ack;
        logic [7:0] rdata;
    } state_t;

    state_t s_q;
    state_t s_d;

    logic [7:0] idx;
    logic hit_cfg;
    logic hit_ctl;
    logic req;
    logic wr_take;
    logic rd_take;
    logic ref_edge;
    logic [4:0] target;
    logic lock_rise;
    logic lock_fall;
    logic [7:0] cfg_view;
    logic [7:0] ctl_view;
    logic [1:0] wsrc;

    assign idx = adr_i[pll_clock_pkg::ADR_W-1:2];
    assign hit_cfg = (idx == pll_clock_pkg::IDX_CFG);
    assign hit_ctl = (idx == pll_clock_pkg::IDX_CTL);
    assign req = cyc_i && stb_i;
    // Writes land on the edge where the master sees ack
    assign wr_take = req && s_q.ack && we_i && sel_i[0];
    assign rd_take = req && s_q.ack && !we_i;
    assign wsrc = dat_i[pll_clock_pkg::SRC_HI:pll_clock_pkg::SRC_LO];

    // Reference clock is far below clk_i, so a synchronized edge is enough
    assign ref_edge = s_q.ref_s2 && !s_q.ref_s3;
    assign target = s_q.sens[0] ? pll_clock_pkg::LOCK_CYCLES_LONG
                                : pll_clock_pkg::LOCK_CYCLES_SHORT;

    // =========================================================
    // Register views; reserved bits stay zero
    always_comb begin
        cfg_view = 8'h00;
        cfg_view[pll_clock_pkg::PUMP_HI:pll_clock_pkg::PUMP_LO] = s_q.pump;
        cfg_view[pll_clock_pkg::SENS_HI:pll_clock_pkg::SENS_LO] = s_q.sens;
        cfg_view[pll_clock_pkg::SRC_HI:pll_clock_pkg::SRC_LO] = s_q.src;
        ctl_view = 8'h00;
        ctl_view[pll_clock_pkg::LOCK_STATE_BIT] = s_q.locked;
        ctl_view[pll_clock_pkg::LOCK_FLAG_BIT] = s_q.lock_flag;
        ctl_view[pll_clock_pkg::UNLOCK_FLAG_BIT] = s_q.unlock_flag;
        ctl_view[pll_clock_pkg::LOCK_IE_BIT] = s_q.lock_ie;
        ctl_view[pll_clock_pkg::UNLOCK_IE_BIT] = s_q.unlock_ie;
        ctl_view[pll_clock_pkg::ENABLE_BIT] = s_q.en;
    end

    // =========================================================
    // Next state
    always_comb begin
        s_d = s_q;
        lock_rise = 1'b0;
        lock_fall = 1'b0;

        // Bus slave: ack one cycle after the request, dropped the next
        s_d.ack = req && !s_q.ack;
        if (req && !s_q.ack) begin
            if (hit_cfg) begin
                s_d.rdata = cfg_view;
            end else if (hit_ctl) begin
                s_d.rdata = ctl_view;
            end else begin
                s_d.rdata = 8'h00;
            end
        end

        // Synchronizers
        s_d.ref_s1 = ref_clk_i;
        s_d.ref_s2 = s_q.ref_s1;
        s_d.ref_s3 = s_q.ref_s2;
        s_d.ok_s1 = phase_ok_i;
        s_d.ok_s2 = s_q.ok_s1;

        // Lock detector: consecutive in-window reference cycles
        if (!s_q.en) begin
            s_d.cnt = 5'h00;
        end else if (ref_edge) begin
            if (!s_q.ok_s2) begin
                s_d.cnt = 5'h00;
            end else if (s_q.cnt < target) begin
                s_d.cnt = s_q.cnt + 5'h01;
            end
        end
        s_d.locked = s_q.en && (s_d.cnt >= target);
        lock_rise = s_d.locked && !s_q.locked;
        lock_fall = !s_d.locked && s_q.locked;

        // Read clears only flags the master actually saw set
        if (rd_take && hit_ctl) begin
            if (s_q.rdata[pll_clock_pkg::LOCK_FLAG_BIT]) begin
                s_d.lock_flag = 1'b0;
            end
            if (s_q.rdata[pll_clock_pkg::UNLOCK_FLAG_BIT]) begin
                s_d.unlock_flag = 1'b0;
            end
        end

        if (wr_take && hit_cfg) begin
            if (!s_q.en) begin
                s_d.pump = dat_i[pll_clock_pkg::PUMP_HI:pll_clock_pkg::PUMP_LO];
                s_d.sens = dat_i[pll_clock_pkg::SENS_HI:pll_clock_pkg::SENS_LO];
            end
            if (wsrc == pll_clock_pkg::SRC_XTAL || wsrc == pll_clock_pkg::SRC_RTC) begin
                s_d.src = wsrc;
            end else if (wsrc == pll_clock_pkg::SRC_PLL && s_q.en && s_q.locked) begin
                s_d.src = wsrc;
            end
            // SRC_KEEP falls through and leaves the source alone
        end

        if (wr_take && hit_ctl) begin
            s_d.lock_ie = dat_i[pll_clock_pkg::LOCK_IE_BIT];
            s_d.unlock_ie = dat_i[pll_clock_pkg::UNLOCK_IE_BIT];
            // Writing one also clears an event flag
            if (dat_i[pll_clock_pkg::LOCK_FLAG_BIT]) begin
                s_d.lock_flag = 1'b0;
            end
            if (dat_i[pll_clock_pkg::UNLOCK_FLAG_BIT]) begin
                s_d.unlock_flag = 1'b0;
            end
            if (dat_i[pll_clock_pkg::ENABLE_BIT] || s_q.src != pll_clock_pkg::SRC_PLL) begin
                s_d.en = dat_i[pll_clock_pkg::ENABLE_BIT];
            end
        end

        // Set beats clear
        if (lock_rise) begin
            s_d.lock_flag = 1'b1;
        end
        if (lock_fall) begin
            s_d.unlock_flag = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // =========================================================
    // Outputs
    assign ack_o = s_q.ack;
    assign dat_o = {24'h00_0000, s_q.rdata};
    assign pump_current_select_o = s_q.pump;
    assign lock_window_long_o = s_q.sens[1];
    assign pll_enable_o = s_q.en;
    assign system_clock_source_select_o = s_q.src;
    // Level interrupt, falls as soon as the flags are cleared
    assign irq_o = (s_q.lock_flag && s_q.lock_ie)
                || (s_q.unlock_flag && s_q.unlock_ie);

    // =========================================================
    // Assertions
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence ctl_write_s;
        wr_take && hit_ctl;
    endsequence

    sequence cfg_write_s;
        wr_take && hit_cfg;
    endsequence

    a_pll_src_guard: assert property (
        (system_clock_source_select_o == pll_clock_pkg::SRC_PLL)
        && !$past(system_clock_source_select_o == pll_clock_pkg::SRC_PLL)
        |-> $past(pll_enable_o) && $past(s_q.locked)
    ) else $error("PLL selected while disabled or unlocked");

    a_keep_on_reserved: assert property (
        cfg_write_s ##0 (wsrc == pll_clock_pkg::SRC_KEEP)
        |=> $stable(system_clock_source_select_o)
    ) else $error("Reserved source value changed the source");

    a_locked_fields: assert property (
        cfg_write_s ##0 pll_enable_o
        |=> $stable(pump_current_select_o) && $stable(s_q.sens)
    ) else $error("Pump or sensitivity changed while enabled");

    a_enable_held: assert property (
        (system_clock_source_select_o == pll_clock_pkg::SRC_PLL) && pll_enable_o
        |=> pll_enable_o
    ) else $error("PLL disabled while it clocks the system");

    a_lock_flag_set: assert property (
        $rose(s_q.locked) |-> s_q.lock_flag
    ) else $error("Lock edge did not set lock flag");

    a_unlock_flag_set: assert property (
        $fell(s_q.locked) |-> s_q.unlock_flag
    ) else $error("Unlock edge did not set unlock flag");

    a_irq_masked: assert property (
        irq_o |-> (s_q.lock_flag && s_q.lock_ie) || (s_q.unlock_flag && s_q.unlock_ie)
    ) else $error("Interrupt without an enabled flag");

    a_read_clears: assert property (
        (rd_take && hit_ctl && s_q.rdata[pll_clock_pkg::LOCK_FLAG_BIT]) ##1 !$rose(s_q.locked)
        |-> !s_q.lock_flag
    ) else $error("Read did not clear lock flag");

    a_lock_needs_count: assert property (
        $rose(s_q.locked) |-> $past(ref_edge) && $past(s_q.ok_s2) && pll_enable_o
    ) else $error("Lock declared without a qualifying reference edge");

    a_ack_one_cycle: assert property (
        req && !ack_o |=> ack_o ##1 !ack_o
    ) else $error("Ack timing broken");

    a_status_zero_off: assert property (
        !pll_enable_o |=> !s_q.locked
    ) else $error("Lock status high while disabled");

    // =========================================================
    // Field, event and read-back checks
    sequence ctl_read_s;
        rd_take && hit_ctl;
    endsequence

    sequence cfg_open_s;
        wr_take && hit_cfg && !s_q.en;
    endsequence

    sequence lock_rise_s;
        $rose(s_q.locked);
    endsequence

    a_pump_write: assert property (
        cfg_open_s
        |=> pump_current_select_o == $past(dat_i[pll_clock_pkg::PUMP_HI:pll_clock_pkg::PUMP_LO])
    ) else $error("Pump select did not take the written value");

    a_sens_write: assert property (
        cfg_open_s
        |=> s_q.sens == $past(dat_i[pll_clock_pkg::SENS_HI:pll_clock_pkg::SENS_LO])
    ) else $error("Lock sensitivity did not take the written value");

    a_window_out: assert property (
        cfg_open_s
        |=> lock_window_long_o == $past(dat_i[pll_clock_pkg::SENS_HI])
    ) else $error("Lock window output does not follow the written field");

    a_src_plain: assert property (
        cfg_write_s ##0 (wsrc == pll_clock_pkg::SRC_XTAL || wsrc == pll_clock_pkg::SRC_RTC)
        |=> system_clock_source_select_o == $past(wsrc)
    ) else $error("Oscillator source write not taken");

    a_src_refused: assert property (
        cfg_write_s ##0 (wsrc == pll_clock_pkg::SRC_PLL) && !(s_q.en && s_q.locked)
        |=> $stable(system_clock_source_select_o)
    ) else $error("PLL source taken while disabled or unlocked");

    a_src_only_write: assert property (
        !(wr_take && hit_cfg)
        |=> $stable(system_clock_source_select_o)
    ) else $error("Clock source changed without a write");

    a_enable_write: assert property (
        ctl_write_s ##0 (dat_i[pll_clock_pkg::ENABLE_BIT] || s_q.src != pll_clock_pkg::SRC_PLL)
        |=> pll_enable_o == $past(dat_i[pll_clock_pkg::ENABLE_BIT])
    ) else $error("Enable write not taken");

    a_lock_irq: assert property (
        s_q.lock_flag && s_q.lock_ie
        |-> irq_o
    ) else $error("Enabled lock flag raised no interrupt");

    a_unlock_irq: assert property (
        s_q.unlock_flag && s_q.unlock_ie
        |-> irq_o
    ) else $error("Enabled unlock flag raised no interrupt");

    a_lock_event_irq: assert property (
        lock_rise_s ##0 s_q.lock_ie
        |-> irq_o
    ) else $error("Lock event did not reach the interrupt output");

    a_unlock_read: assert property (
        (ctl_read_s ##0 s_q.rdata[pll_clock_pkg::UNLOCK_FLAG_BIT]) ##1 !$fell(s_q.locked)
        |-> !s_q.unlock_flag
    ) else $error("Read did not clear unlock flag");

    a_lock_sticky: assert property (
        s_q.lock_flag && !(rd_take && hit_ctl)
        && !(wr_take && hit_ctl && dat_i[pll_clock_pkg::LOCK_FLAG_BIT]) |=> s_q.lock_flag
    ) else $error("Lock flag dropped without a clear");

    a_unlock_sticky: assert property (
        s_q.unlock_flag && !(rd_take && hit_ctl)
        && !(wr_take && hit_ctl && dat_i[pll_clock_pkg::UNLOCK_FLAG_BIT]) |=> s_q.unlock_flag
    ) else $error("Unlock flag dropped without a clear");

    a_count_idle: assert property (
        !s_q.en
        |=> s_q.cnt == 5'h00
    ) else $error("Lock counter ran while disabled");

    a_cfg_reserved: assert property (
        ack_o && !we_i && hit_cfg
        |-> dat_o[5:4] == 2'b00 && dat_o[31:8] == 24'h00_0000
    ) else $error("Reserved config bits read non-zero");

    a_ctl_reserved: assert property (
        ack_o && !we_i && hit_ctl
        |-> dat_o[7:6] == 2'b00 && dat_o[31:8] == 24'h00_0000
    ) else $error("Reserved control bits read non-zero");

    a_status_read: assert property (
        ack_o && !we_i && hit_ctl
        |-> dat_o[pll_clock_pkg::LOCK_STATE_BIT] == $past(s_q.locked)
    ) else $error("Lock status read back wrong");

    a_flag_read: assert property (
        ack_o && !we_i && hit_ctl
        |-> dat_o[pll_clock_pkg::LOCK_FLAG_BIT] == $past(s_q.lock_flag)
    ) else $error("Lock flag read back wrong");

endmodule

// ---- src/pll_clock_pkg.sv ----
package pll_clock_pkg;

    // =========================================================
    // Register map: offsets are word indices, byte address = 4 * index
    localparam logic [7:0] IDX_CFG = 8'h5e;
    localparam logic [7:0] IDX_CTL = 8'h5f;
    localparam int ADR_W = 10;

    // =========================================================
    // Configuration register fields
    localparam int PUMP_HI = 7;
    localparam int PUMP_LO = 6;
    localparam int SENS_HI = 3;
    localparam int SENS_LO = 2;
    localparam int SRC_HI = 1;
    localparam int SRC_LO = 0;
    localparam logic [7:0] CFG_RESET = 8'h00;

    // =========================================================
    // Enable and event register fields
    localparam int LOCK_STATE_BIT = 5;
    localparam int LOCK_FLAG_BIT = 4;
    localparam int UNLOCK_FLAG_BIT = 3;
    localparam int LOCK_IE_BIT = 2;
    localparam int UNLOCK_IE_BIT = 1;
    localparam int ENABLE_BIT = 0;
    localparam logic [7:0] CTL_RESET = 8'h00;

    // =========================================================
    // Encodings
    localparam logic [1:0] PUMP_100UA = 2'h0;
    localparam logic [1:0] PUMP_500UA = 2'h1;
    localparam logic [1:0] PUMP_1MA0 = 2'h2;
    localparam logic [1:0] PUMP_1MA5 = 2'h3;

    typedef enum logic [1:0] {
        SRC_XTAL = 2'b00,
        SRC_PLL = 2'b01,
        SRC_RTC = 2'b10,
        SRC_KEEP = 2'b11
    } clock_source_t;

    // =========================================================
    // Lock criteria: window bit [3] picks 20 ns or 400 ns, bit [2] the cycle count
    localparam int WINDOW_SHORT_NS = 20;
    localparam int WINDOW_LONG_NS = 400;
    localparam logic [4:0] LOCK_CYCLES_SHORT = 5'h08;
    localparam logic [4:0] LOCK_CYCLES_LONG = 5'h10;
endpackage

// ---- tb/pll_analog_model.sv ----
`timescale 1ns/100ps
module pll_analog_model (
    input wire logic enable_i,
    input wire logic hold_lock_i,
    output logic ref_clk_o,
    output logic phase_ok_o
);
    // =========================================================
    // Crystal reference
    // Runs free at 2.5 MHz, slow enough for the three sync flops of the block
    initial ref_clk_o = 1'b0;
    always #200 ref_clk_o = ~ref_clk_o;

    // =========================================================
    // Phase comparison
    // Settles only while the loop is powered; the bench drops hold_lock_i to force a slip
    initial phase_ok_o = 1'b0;
    always @(negedge ref_clk_o) phase_ok_o <= enable_i & hold_lock_i;
endmodule

// ---- tb/pll_clock_source_control_tb.sv ----
`timescale 1ns/100ps
module pll_clock_source_control_tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [9:0] adr_i = 10'h000;
    logic [3:0] sel_i = 4'h1;
    logic [31:0] dat_i = 32'h0000_0000;
    logic [31:0] dat_o;
    logic ack_o, ref_clk, phase_ok, lock_window_long_o, pll_enable_o, irq_o, hold_lock;
    logic [1:0] pump_current_select_o, system_clock_source_select_o;
    int mismatches = 0;
    int n_compared = 0;
    localparam logic [9:0] CFG = 10'h178;
    localparam logic [9:0] CTL = 10'h17c;

    always #20 clk_i = ~clk_i;

    pll_analog_model analog (.enable_i(pll_enable_o), .hold_lock_i(hold_lock),
        .ref_clk_o(ref_clk), .phase_ok_o(phase_ok));

    pll_clock_source_control dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
        .ack_o(ack_o), .ref_clk_i(ref_clk), .phase_ok_i(phase_ok),
        .pump_current_select_o(pump_current_select_o),
        .lock_window_long_o(lock_window_long_o), .pll_enable_o(pll_enable_o),
        .system_clock_source_select_o(system_clock_source_select_o), .irq_o(irq_o));

    // =========================================================
    // Bus and check helpers
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d,
            output logic [7:0] q);
        int n;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= {24'h00_0000, d};
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        q = dat_o[7:0];
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        if (n >= 50) chk("ack", 8'h01, 8'h00);
    endtask

    task automatic rd(input string what, input logic [9:0] a, input logic [7:0] exp);
        logic [7:0] q;
        bus(1'b0, a, 8'h00, q);
        chk(what, exp, q);
    endtask

    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic wait_irq();
        int n;
        n = 0;
        while (irq_o !== 1'b1 && n < 2000) begin
            @(posedge clk_i);
            n++;
        end
        chk("irq rise", 8'h01, {7'h00, irq_o});
    endtask

    // =========================================================
    // Scenarios
    task automatic t_reset();
        rd("cfg reset", CFG, 8'h00);
        rd("ctl reset", CTL, 8'h00);
        chk("outs reset", 8'h00, {pll_enable_o, system_clock_source_select_o});
        rd("unmapped", 10'h000, 8'h00);
        $display("test reset done");
    endtask

    task automatic t_config();
        for (int i = 0; i < 4; i++) begin
            wr(CFG, {i[1:0], 2'b11, i[1:0], 2'b10});
            rd("cfg fields", CFG, {i[1:0], 2'b00, i[1:0], 2'b10});
            chk("pump", {6'h00, i[1:0]}, {6'h00, pump_current_select_o});
            chk("window", {7'h00, i[1]}, {7'h00, lock_window_long_o});
            chk("rtc src", 8'h02, {6'h00, system_clock_source_select_o});
        end
        wr(CFG, 8'hff);
        rd("src keep", CFG, 8'hce);
        wr(CFG, 8'h01);
        rd("pll off", CFG, 8'h02);
        wr(CFG, 8'h40);
        rd("xtal src", CFG, 8'h40);
        $display("test config done");
    endtask

    task automatic t_lock();
        wr(CTL, 8'he5);
        rd("enable", CTL, 8'h05);
        wr(CFG, 8'hc9);
        rd("cfg locked", CFG, 8'h40);
        wait_irq();
        rd("lock flag", CTL, 8'h35);
        rd("flag clear", CTL, 8'h25);
        chk("irq clear", 8'h00, {7'h00, irq_o});
        wr(CFG, 8'h41);
        wr(CTL, 8'h00);
        rd("en kept", CTL, 8'h21);
        chk("pll src", 8'h05, {5'h00, pll_enable_o, system_clock_source_select_o});
        $display("test lock done");
    endtask

    task automatic t_unlock();
        wr(CTL, 8'h03);
        hold_lock <= 1'b0;
        wait_irq();
        rd("unlock flag", CTL, 8'h0b);
        rd("src stays", CFG, 8'h41);
        hold_lock <= 1'b1;
        repeat (300) @(posedge clk_i);
        chk("lock masked", 8'h00, {7'h00, irq_o});
        rd("masked flag", CTL, 8'h33);
        rd("all clear", CTL, 8'h23);
        $display("test unlock done");
    endtask

    // =========================================================
    // Run control
    task automatic wrap_up();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        hold_lock = 1'b1;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_config();
        t_lock();
        t_unlock();
        wrap_up();
    end

    // Lock runs take under a hundred cycles each; this leaves ample slack
    initial begin
        #(40 * 20000);
        mismatches++;
        wrap_up();
    end
endmodule
